// file: scm_pkg.sv
package scm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL  = 8'h08;
    localparam logic [7:0] OFS_MODE0    = 8'h0c;
    localparam logic [7:0] OFS_MODE1    = 8'h18;
    // Control register field positions
    localparam int CR_RX9   = 7;
    localparam int CR_EVEN  = 6;
    localparam int CR_PEN   = 5;
    localparam int CR_OVR   = 4;
    localparam int CR_PAR   = 3;
    localparam int CR_FRM   = 2;
    localparam int CR_EDGE  = 1;
    localparam int CR_IOC   = 0;
    // Mode register 0 field positions
    localparam int M0_TX9   = 7;
    localparam int M0_CTS   = 6;
    localparam int M0_RXE   = 5;
    localparam int M0_WAKE  = 4;
    localparam int M0_FMT   = 2;
    localparam int M0_CLK   = 0;
    // Reset values and the mode register 1 write mask
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE0_RESET   = 8'h00;
    localparam logic [7:0] MODE1_RESET   = 8'h00;
    localparam logic [7:0] MODE1_WMASK   = 8'hfe;
    // Transfer format codes
    localparam logic [1:0] FMT_IO   = 2'h0;
    localparam logic [1:0] FMT_7BIT = 2'h1;
    localparam logic [1:0] FMT_8BIT = 2'h2;
    localparam logic [1:0] FMT_9BIT = 2'h3;
    // Clock source codes
    localparam logic [2:0] SRC_TIMER = 3'h0;
    localparam logic [2:0] SRC_BAUD  = 3'h1;
    localparam logic [2:0] SRC_SYS   = 3'h2;
    localparam logic [2:0] SRC_PIN   = 3'h3;
endpackage

// file: scm_channel.sv
module scm_channel
    import scm_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [7:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    // Events from the shift engine
    input  wire logic        RX_DONE,
    input  wire logic        RX_NINTH,
    input  wire logic        RX_PARITY_BAD,
    input  wire logic        RX_FRAME_BAD,
    input  wire logic        RX_OVERRUN,
    input  wire logic        TX_UNDERRUN,
    // Pins
    input  wire logic        CTS_N,
    // Configuration to the shift engine, and the receive interrupt
    output logic             RX_RUN,
    output logic             TX_ALLOW,
    output logic             TX_NINTH,
    output logic             PARITY_ON,
    output logic             PARITY_EVEN,
    output logic      [3:0]  DATA_BITS,
    output logic      [2:0]  CLOCK_SOURCE,
    output logic             SHIFT_FALLING,
    output logic             RX_IRQ
);
    logic [7:0] channel_control;
    logic       received_ninth_bit_q;
    logic       parity_even_q;
    logic       parity_add_enable_q;
    logic       overrun_flag_q;
    logic       parity_underrun_flag_q;
    logic       framing_flag_q;
    logic       shift_edge_select_q;
    logic       io_clock_select_q;
    logic [7:0] mode0_q;
    logic [7:0] mode1_q;
    logic       ack_q;
    logic [31:0] rdata_q;
    logic [1:0] cts_sync_q;
    logic       wr_en;
    logic       rd_en;
    logic       rd_ctrl;
    logic       async_mode;
    logic       nine_mode;
    logic [1:0] fmt;

    assign fmt        = mode0_q[M0_FMT +: 2];
    assign async_mode = (fmt != FMT_IO);
    assign nine_mode  = (fmt == FMT_9BIT);
    assign wr_en      = WB_CYC && WB_STB && WB_WE && !ack_q && WB_SEL[0];
    assign rd_en      = WB_CYC && WB_STB && !WB_WE && !ack_q;
    assign rd_ctrl    = rd_en && (WB_ADR == OFS_CONTROL);

    // One wait state answer; ack drops the cycle after
    always_ff @(posedge CLK)
    begin
        if (RESET)
            ack_q <= 1'b0;
        else
            ack_q <= WB_CYC && WB_STB && !ack_q;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            rdata_q <= 32'h0;
        else if (rd_en)
        begin
            if (WB_ADR == OFS_CONTROL)
                rdata_q <= {24'h0, channel_control};
            else if (WB_ADR == OFS_MODE0)
                rdata_q <= {24'h0, mode0_q};
            else if (WB_ADR == OFS_MODE1)
                rdata_q <= {24'h0, mode1_q};
            else
                rdata_q <= 32'h0;
        end
    end

    // Register image; each field has a single owner below
    always_comb
    begin
        channel_control          = 8'h00;
        channel_control[CR_RX9]  = received_ninth_bit_q;
        channel_control[CR_EVEN] = parity_even_q;
        channel_control[CR_PEN]  = parity_add_enable_q;
        channel_control[CR_OVR]  = overrun_flag_q;
        channel_control[CR_PAR]  = parity_underrun_flag_q;
        channel_control[CR_FRM]  = framing_flag_q;
        channel_control[CR_EDGE] = shift_edge_select_q;
        channel_control[CR_IOC]  = io_clock_select_q;
    end

    // Writable control fields
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            parity_even_q       <= CONTROL_RESET[CR_EVEN];
            parity_add_enable_q <= CONTROL_RESET[CR_PEN];
            shift_edge_select_q <= CONTROL_RESET[CR_EDGE];
            io_clock_select_q   <= CONTROL_RESET[CR_IOC];
        end
        else if (wr_en && WB_ADR == OFS_CONTROL)
        begin
            parity_even_q       <= WB_DAT_I[CR_EVEN];
            parity_add_enable_q <= WB_DAT_I[CR_PEN];
            shift_edge_select_q <= WB_DAT_I[CR_EDGE];
            io_clock_select_q   <= WB_DAT_I[CR_IOC];
        end
    end

    // ninth bit captured on 9-bit frames
    always_ff @(posedge CLK)
    begin
        if (RESET)
            received_ninth_bit_q <= CONTROL_RESET[CR_RX9];
        else if (RX_DONE && nine_mode && mode0_q[M0_RXE])
            received_ninth_bit_q <= RX_NINTH;
    end

    // overrun flag, set beats read clear
    always_ff @(posedge CLK)
    begin
        if (RESET)
            overrun_flag_q <= CONTROL_RESET[CR_OVR];
        else if (RX_OVERRUN && mode0_q[M0_RXE])
            overrun_flag_q <= 1'b1;
        else if (rd_ctrl)
            overrun_flag_q <= 1'b0;
    end

    // parity in async, underrun in IO
    always_ff @(posedge CLK)
    begin
        if (RESET)
            parity_underrun_flag_q <= CONTROL_RESET[CR_PAR];
        else if ((async_mode && RX_DONE && mode0_q[M0_RXE]
                  && parity_add_enable_q && RX_PARITY_BAD)
                 || (!async_mode && TX_UNDERRUN))
            parity_underrun_flag_q <= 1'b1;
        else if (rd_ctrl)
            parity_underrun_flag_q <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
            framing_flag_q <= CONTROL_RESET[CR_FRM];
        else if (RX_DONE && mode0_q[M0_RXE] && RX_FRAME_BAD)
            framing_flag_q <= 1'b1;
        else if (rd_ctrl)
            framing_flag_q <= 1'b0;
    end

    // Mode registers, low byte lane only
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            mode0_q <= MODE0_RESET;
            mode1_q <= MODE1_RESET;
        end
        else if (wr_en && WB_ADR == OFS_MODE0)
            mode0_q <= WB_DAT_I[7:0];
        else if (wr_en && WB_ADR == OFS_MODE1)
            mode1_q <= WB_DAT_I[7:0] & MODE1_WMASK;
    end

    // Pin synchroniser; first stage read only by second
    always_ff @(posedge CLK)
    begin
        if (RESET)
            cts_sync_q <= 2'h3;
        else
            cts_sync_q <= {cts_sync_q[0], CTS_N};
    end

    // Outputs to the shift engine and the receive interrupt, all registered
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            RX_RUN        <= 1'b0;
            TX_ALLOW      <= 1'b0;
            TX_NINTH      <= 1'b0;
            PARITY_ON     <= 1'b0;
            PARITY_EVEN   <= 1'b0;
            DATA_BITS     <= 4'h0;
            CLOCK_SOURCE  <= SRC_TIMER;
            SHIFT_FALLING <= 1'b0;
            RX_IRQ        <= 1'b0;
        end
        else
        begin
            RX_RUN <= mode0_q[M0_RXE];
            TX_ALLOW <= !mode0_q[M0_CTS] || !cts_sync_q[1];
            // ninth transmit bit in 9-bit mode
            TX_NINTH <= nine_mode && mode0_q[M0_TX9];
            PARITY_ON <= async_mode && parity_add_enable_q;
            PARITY_EVEN <= parity_even_q;
            case (fmt)
                FMT_7BIT: DATA_BITS <= 4'h7;
                FMT_8BIT: DATA_BITS <= 4'h8;
                FMT_9BIT: DATA_BITS <= 4'h9;
                default:  DATA_BITS <= 4'h8;
            endcase
            if (async_mode)
                CLOCK_SOURCE <= {1'b0, mode0_q[M0_CLK +: 2]};
            else if (io_clock_select_q)
                CLOCK_SOURCE <= SRC_PIN;
            else
                CLOCK_SOURCE <= SRC_BAUD;
            // edge select in IO mode only
            SHIFT_FALLING <= !async_mode && shift_edge_select_q;
            RX_IRQ <= RX_DONE && mode0_q[M0_RXE]
                      && !(nine_mode && mode0_q[M0_WAKE] && !RX_NINTH);
        end
    end

    assign WB_ACK   = ack_q;
    assign WB_DAT_O = rdata_q;

    // Assertions
    sequence ctrl_read_s;
        WB_CYC && WB_STB && !WB_WE && !ack_q && WB_ADR == OFS_CONTROL;
    endsequence

    property flag_clear_p;
        @(posedge CLK) disable iff (RESET)
        ctrl_read_s ##0 !RX_FRAME_BAD ##1 1 |-> !framing_flag_q;
    endproperty
    flag_clear_a: assert property (flag_clear_p)
        else $error("framing flag not cleared by read");

    overrun_set_a: assert property (
        @(posedge CLK) disable iff (RESET)
        RX_OVERRUN && mode0_q[M0_RXE] |=> overrun_flag_q)
        else $error("overrun flag not set");

    underrun_set_a: assert property (
        @(posedge CLK) disable iff (RESET)
        !async_mode && TX_UNDERRUN |=> parity_underrun_flag_q)
        else $error("underrun flag not set");

    ack_pulse_a: assert property (
        @(posedge CLK) disable iff (RESET)
        WB_ACK |=> !WB_ACK)
        else $error("ack held two cycles");

    upper_zero_a: assert property (
        @(posedge CLK) disable iff (RESET)
        WB_ACK |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read bits not zero");

    rx_gate_a: assert property (
        @(posedge CLK) disable iff (RESET)
        !mode0_q[M0_RXE] |=> !RX_RUN && !RX_IRQ)
        else $error("receiver active while disabled");

    cts_gate_a: assert property (
        @(posedge CLK) disable iff (RESET)
        mode0_q[M0_CTS] && cts_sync_q[1] |=> !TX_ALLOW)
        else $error("transmit not held by CTS");

    wake_filter_a: assert property (
        @(posedge CLK) disable iff (RESET)
        nine_mode && mode0_q[M0_WAKE] && !RX_NINTH |=> !RX_IRQ)
        else $error("wake filter passed ninth bit zero");

    io_clock_a: assert property (
        @(posedge CLK) disable iff (RESET)
        !async_mode && io_clock_select_q |=> CLOCK_SOURCE == SRC_PIN)
        else $error("IO clock source wrong");

    // One accepted end of frame
    sequence frame_end_s;
        RX_DONE && mode0_q[M0_RXE];
    endsequence

    parity_set_a: assert property (
        @(posedge CLK) disable iff (RESET)
        frame_end_s ##0 (async_mode && parity_add_enable_q && RX_PARITY_BAD)
        |=> parity_underrun_flag_q)
        else $error("parity flag not set");

    framing_set_a: assert property (
        @(posedge CLK) disable iff (RESET)
        frame_end_s ##0 RX_FRAME_BAD |=> framing_flag_q)
        else $error("framing flag not set");

    ninth_store_a: assert property (
        @(posedge CLK) disable iff (RESET)
        frame_end_s ##0 nine_mode
        |=> received_ninth_bit_q == $past(RX_NINTH))
        else $error("ninth bit not stored");

    overrun_clear_a: assert property (
        @(posedge CLK) disable iff (RESET)
        ctrl_read_s ##0 !RX_OVERRUN |=> !overrun_flag_q)
        else $error("overrun flag not cleared by read");

    read_only_a: assert property (
        @(posedge CLK) disable iff (RESET)
        wr_en && WB_ADR == OFS_CONTROL && !RX_DONE && !RX_OVERRUN
        && !TX_UNDERRUN |=> $stable({received_ninth_bit_q, overrun_flag_q,
        parity_underrun_flag_q, framing_flag_q}))
        else $error("read-only control bits changed by write");

    parity_off_a: assert property (
        @(posedge CLK) disable iff (RESET)
        !(async_mode && parity_add_enable_q) |=> !PARITY_ON)
        else $error("parity active outside async with enable");

    async_src_a: assert property (
        @(posedge CLK) disable iff (RESET)
        async_mode |=> CLOCK_SOURCE == {1'b0, $past(mode0_q[M0_CLK +: 2])})
        else $error("async clock source wrong");
endmodule

// file: scm_far_end.sv
module scm_far_end (
    // Clock
    input  wire logic       CLK,
    // Events and pin toward the channel
    output logic            RX_DONE,
    output logic            RX_NINTH,
    output logic            RX_PARITY_BAD,
    output logic            RX_FRAME_BAD,
    output logic            RX_OVERRUN,
    output logic            TX_UNDERRUN,
    output logic            CTS_N
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       tog_q  = 1'b0;
    logic [2:0] qual_q = 3'h0;
    // Qualifiers mean nothing between frames, so keep them moving
    always @(posedge CLK) tog_q <= ~tog_q;
    assign RX_NINTH      = RX_DONE ? qual_q[2] : tog_q;
    assign RX_PARITY_BAD = RX_DONE ? qual_q[1] : ~tog_q;
    assign RX_FRAME_BAD  = RX_DONE ? qual_q[0] : tog_q;
    initial
    begin
        RX_DONE     = 1'b0;
        RX_OVERRUN  = 1'b0;
        TX_UNDERRUN = 1'b0;
        CTS_N       = 1'b1;
    end
    // Frame end: ninth bit, parity bad, framing bad
    task automatic frame(input logic [2:0] q);
        @(posedge CLK);
        RX_DONE <= 1'b1;
        qual_q  <= q;
        @(posedge CLK);
        RX_DONE <= 1'b0;
    endtask
    task automatic pulse(input logic ovr, input logic udr);
        @(posedge CLK);
        RX_OVERRUN  <= ovr;
        TX_UNDERRUN <= udr;
        @(posedge CLK);
        RX_OVERRUN  <= 1'b0;
        TX_UNDERRUN <= 1'b0;
    endtask
    task automatic cts(input logic v);
        @(posedge CLK);
        CTS_N <= v;
    endtask
endmodule

// file: serial_channel_control_mode_tb.sv
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module serial_channel_control_mode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scm_pkg::*;
    logic        clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, r, m0, cr, x;
    logic        ack, done, n9, pb, fb, ovr, udr, cts_n, run, allow, t9;
    logic        pon, pev, fall, irq;
    logic [3:0]  bits;
    logic [2:0]  src, e_src;
    logic [1:0]  fmt;
    logic [31:0] exp_q[$];
    int          n_errors = 0, checks = 0, irqs = 0, base;
    integer      seed = 32'h40097965;
    scm_channel dut (.CLK(clk), .RESET(reset), .WB_CYC(cyc), .WB_STB(stb),
        .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat),
        .WB_DAT_O(dat_o), .WB_ACK(ack), .RX_DONE(done), .RX_NINTH(n9),
        .RX_PARITY_BAD(pb), .RX_FRAME_BAD(fb), .RX_OVERRUN(ovr),
        .TX_UNDERRUN(udr), .CTS_N(cts_n), .RX_RUN(run), .TX_ALLOW(allow),
        .TX_NINTH(t9), .PARITY_ON(pon), .PARITY_EVEN(pev), .DATA_BITS(bits),
        .CLOCK_SOURCE(src), .SHIFT_FALLING(fall), .RX_IRQ(irq));
    scm_far_end far (.CLK(clk), .RX_DONE(done), .RX_NINTH(n9),
        .RX_PARITY_BAD(pb), .RX_FRAME_BAD(fb), .RX_OVERRUN(ovr),
        .TX_UNDERRUN(udr), .CTS_N(cts_n));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task automatic give_verdict;
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One classic cycle; reads leave their expectation for the monitor
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // Only the watchdog ends a wait that never sees ack
        do
            @(posedge clk);
        while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask
    always @(posedge clk)
    begin
        if (irq === 1'b1)
            irqs++;
        if (ack === 1'b1 && !we && exp_q.size() > 0)
        begin
            x = exp_q.pop_front();
            `CHK("read data", x, dat_o)
        end
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_CONTROL, 32'h0);
        rd(8'h10, 32'h0);
        wr(OFS_MODE1, 32'hffffffff);
        wb(1'b1, 8'h10, 32'hff, 4'hf);
        rd(OFS_MODE1, {24'h0, MODE1_WMASK});
        wb(1'b1, OFS_MODE1, 32'h0, 4'he);
        rd(OFS_MODE1, {24'h0, MODE1_WMASK});
        for (int i = 0; i < 8; i++)
        begin
            r   = $random(seed);
            fmt = 2'(i);
            m0 = {24'h0, r[7], 2'b00, r[4], fmt, 2'(i >> 1)};
            // no parity in 9-bit, rising edge with clock out
            cr = {24'h0, 1'b0, r[6], r[5] & (fmt != FMT_9BIT), 3'b000,
                  r[9] & r[8], r[8]};
            wr(OFS_MODE0, m0);
            wr(OFS_CONTROL, cr | {24'h0, r[15], 2'b00, r[14:12], 2'b00});
            rd(OFS_MODE0, m0);
            rd(OFS_CONTROL, cr);
            `CHK("bits", fmt == FMT_IO ? 4'h8 : 4'(fmt) + 4'h6, bits)
            if (fmt != FMT_IO)
                e_src = 3'(i >> 1);
            else
                e_src = cr[0] ? SRC_PIN : SRC_BAUD;
            `CHK("src", e_src, src)
            `CHK("fall", fmt == FMT_IO && cr[1], fall)
            `CHK("par on", fmt != FMT_IO && cr[5], pon)
            if (fmt != FMT_IO)
                `CHK("even", cr[6], pev)
            `CHK("tx9", fmt == FMT_9BIT && m0[7], t9)
        end
        wr(OFS_MODE0, 32'h09);
        wr(OFS_MODE0, 32'h29);
        wr(OFS_CONTROL, 32'h20);
        `CHK("run", 1'b1, run)
        base = irqs;
        far.frame(3'b111);
        far.pulse(1'b1, 1'b0);
        rd(OFS_CONTROL, 32'h3c);
        rd(OFS_CONTROL, 32'h20);
        `CHK("irq", base + 1, irqs)
        wr(OFS_CONTROL, 32'h0);
        far.frame(3'b010);
        rd(OFS_CONTROL, 32'h0);
        wr(OFS_MODE0, 32'h1d);
        wr(OFS_MODE0, 32'h3d);
        base = irqs;
        far.frame(3'b000);
        far.frame(3'b100);
        rd(OFS_CONTROL, 32'h80);
        `CHK("wake irq", base + 1, irqs)
        wr(OFS_MODE0, 32'h0c);
        far.frame(3'b011);
        `CHK("run", 1'b0, run)
        // Underrun counts only in IO mode
        far.pulse(1'b0, 1'b1);
        rd(OFS_CONTROL, 32'h80);
        `CHK("off irq", base + 1, irqs)
        wr(OFS_MODE0, 32'h00);
        far.pulse(1'b0, 1'b1);
        rd(OFS_CONTROL, 32'h88);
        wr(OFS_MODE0, 32'h40);
        for (int k = 0; k < 3; k++)
        begin
            far.cts(k != 1);
            if (k == 2)
                wr(OFS_MODE0, 32'h0);
            repeat (6) @(posedge clk);
            `CHK("allow", k != 0, allow)
        end
        give_verdict();
    end
endmodule
